// File: logic/cod_pkg.sv
// Constants and carrier types for the comparator open-diagnostic threshold bank
// Function
// R01 - Cell open limit 15:4, undervoltage sets cell alert
// R02 - Cell limit only for unipolar open diagnostic
// R03 - Zero cell limit disables cell open check
// R04 - Ratiometric aux open limit sets aux alert
// R05 - Ratiometric limit when reference select is zero
// R06 - Absolute aux open limit sets aux alert
// R07 - Absolute limit when reference select is one
// R08 - Zero aux limit disables aux open check
// R09 - Limits read/write, open limits reset zero
// R10 - Accuracy overvoltage limit resets to all ones
// R11 - Reading above accuracy limit sets accuracy alert
// R12 - Accuracy check: scan 001/010 and enable set
// R13 - Limit bits 3:0 read zero, writes ignored
// R14 - Unsigned strict compare on aligned 12 bits
package cod_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CELL_LIM = 8'h3E;
    localparam logic [7:0] IDX_RATIO_LIM = 8'h3F;
    localparam logic [7:0] IDX_ABS_LIM = 8'h40;
    localparam logic [7:0] IDX_ACC_LIM = 8'h41;
    localparam logic [7:0] IDX_CFG = 8'h50;
    localparam logic [7:0] IDX_STATUS = 8'h51;
    localparam logic [7:0] IDX_MASK = 8'h52;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // Limit field layout and reset values
    // ------------------------------------------------------------
    localparam int LIM_W = 12;
    localparam int LIM_LSB = 4;
    localparam int LIM_MSB = 15;
    localparam logic [11:0] LIM_RST_OPEN = 12'h000;
    localparam logic [11:0] LIM_RST_ACC = 12'hFFF;
    localparam logic [11:0] LIM_OFF_UV = 12'h000;
    localparam logic [11:0] LIM_OFF_OV = 12'hFFF;

    // ------------------------------------------------------------
    // Configuration register fields
    // ------------------------------------------------------------
    localparam int CFG_CELL_OPEN = 0;
    localparam int CFG_AUX_DIAG_LSB = 1;
    localparam int CFG_SCAN_LSB = 3;
    localparam int CFG_ACC_EN = 6;
    localparam int CFG_AUX_REF_LSB = 8;
    localparam int NUM_AUX = 6;
    localparam logic [1:0] AUX_DIAG_OPEN = 2'h1;
    localparam logic [2:0] SCAN_ACC_A = 3'h1;
    localparam logic [2:0] SCAN_ACC_B = 3'h2;

    // ------------------------------------------------------------
    // Alert status bits, shared by status and mask
    // ------------------------------------------------------------
    localparam int ST_CELL_UV = 0;
    localparam int ST_AUX_UV = 1;
    localparam int ST_ACC_OV = 2;
    localparam int NUM_ALERT = 3;

    // ------------------------------------------------------------
    // Measurement sources
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_CELL = 2'h0;
    localparam logic [1:0] SRC_AUX = 2'h1;
    localparam logic [1:0] SRC_ACC = 2'h2;

    typedef struct packed {
        logic valid;
        logic [1:0] src;
        logic [2:0] chan;
        logic unipolar;
        logic [11:0] value;
    } cod_meas_t;

    typedef struct packed {
        logic cell_open_sel;
        logic [1:0] aux_diag_sel;
        logic [2:0] scan_cfg;
        logic acc_en;
        logic [5:0] aux_ref_sel;
    } cod_cfg_t;

endpackage

// File: logic/cod_lim_cmp.sv
// One threshold comparison with the disable value honoured
`timescale 1ns/1ns
`default_nettype none
module cod_lim_cmp
    import cod_pkg::*;
(
    // Operands
    input wire logic [11:0] value,
    input wire logic [11:0] limit,
    input wire logic over,
    // Result
    output logic hit
);

    // ------------------------------------------------------------
    // Unsigned strict compare, disable codes never hit
    // ------------------------------------------------------------
    always_comb begin
        if (over) begin
            hit = (limit != LIM_OFF_OV) && (value > limit); // [R14]
        end else begin
            hit = (limit != LIM_OFF_UV) && (value < limit); // [R14]
        end
    end

endmodule
`default_nettype wire

// File: logic/cod_thresh_bank.sv
// Open-diagnostic and accuracy threshold bank with APB slave and alerts
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cod_thresh_bank
    import cod_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator results
    input wire cod_meas_t meas,
    // Alerts
    output logic cell_comp_uv_alert,
    output logic aux_comp_uv_alert,
    output logic comp_accuracy_ov_alert,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] cell_lim;
        logic [11:0] ratio_lim;
        logic [11:0] abs_lim;
        logic [11:0] acc_lim;
        cod_cfg_t cfg;
        logic [2:0] status;
        logic [2:0] mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } cod_state_t;

    cod_state_t s_r;
    cod_state_t s_nxt;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic in_range;
    logic hit_addr;
    logic is_lim;
    logic access;
    logic complete;
    logic [31:0] rd_data;

    assign idx = paddr[9:2];
    // Upper bits and byte offset must be zero for a mapped word
    assign in_range = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    assign is_lim = (idx == IDX_CELL_LIM) || (idx == IDX_RATIO_LIM) ||
                    (idx == IDX_ABS_LIM) || (idx == IDX_ACC_LIM);
    assign hit_addr = in_range && (is_lim || (idx == IDX_CFG) ||
                      (idx == IDX_STATUS) || (idx == IDX_MASK));
    assign access = psel && penable && !s_r.pready;
    assign complete = psel && penable && s_r.pready;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        if (in_range) begin
            case (idx)
                IDX_CELL_LIM: begin
                    rd_data[LIM_MSB:LIM_LSB] = s_r.cell_lim; // [R09] [R13]
                end
                IDX_RATIO_LIM: begin
                    rd_data[LIM_MSB:LIM_LSB] = s_r.ratio_lim; // [R09] [R13]
                end
                IDX_ABS_LIM: begin
                    rd_data[LIM_MSB:LIM_LSB] = s_r.abs_lim; // [R09] [R13]
                end
                IDX_ACC_LIM: begin
                    rd_data[LIM_MSB:LIM_LSB] = s_r.acc_lim; // [R09] [R13]
                end
                IDX_CFG: begin
                    rd_data[CFG_CELL_OPEN] = s_r.cfg.cell_open_sel;
                    rd_data[CFG_AUX_DIAG_LSB +: 2] = s_r.cfg.aux_diag_sel;
                    rd_data[CFG_SCAN_LSB +: 3] = s_r.cfg.scan_cfg;
                    rd_data[CFG_ACC_EN] = s_r.cfg.acc_en;
                    rd_data[CFG_AUX_REF_LSB +: NUM_AUX] = s_r.cfg.aux_ref_sel;
                end
                IDX_STATUS: begin
                    rd_data[NUM_ALERT-1:0] = s_r.status;
                end
                IDX_MASK: begin
                    rd_data[NUM_ALERT-1:0] = s_r.mask;
                end
                default: begin
                    rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Threshold checks
    // ------------------------------------------------------------
    logic aux_ref;
    logic cell_open_scan;
    logic aux_open_scan;
    logic acc_scan;
    logic [11:0] lim_sel [NUM_ALERT];
    logic over_sel [NUM_ALERT];
    logic [NUM_ALERT-1:0] cmp_hit;
    logic [NUM_ALERT-1:0] set;

    // Out-of-range channel reads as ratiometric rather than faulting
    assign aux_ref = (meas.chan < 3'(NUM_AUX)) ? s_r.cfg.aux_ref_sel[meas.chan] : 1'b0;

    assign cell_open_scan = meas.valid && (meas.src == SRC_CELL) &&
                            meas.unipolar && s_r.cfg.cell_open_sel; // [R02]
    assign aux_open_scan = meas.valid && (meas.src == SRC_AUX) &&
                           (s_r.cfg.aux_diag_sel == AUX_DIAG_OPEN); // [R04] [R06]
    assign acc_scan = meas.valid && (meas.src == SRC_ACC) && s_r.cfg.acc_en &&
                      ((s_r.cfg.scan_cfg == SCAN_ACC_A) ||
                       (s_r.cfg.scan_cfg == SCAN_ACC_B)); // [R12]

    assign lim_sel[ST_CELL_UV] = s_r.cell_lim; // [R01]
    // Reference select picks which aux limit applies
    assign lim_sel[ST_AUX_UV] = aux_ref ? s_r.abs_lim : s_r.ratio_lim; // [R05] [R07]
    assign lim_sel[ST_ACC_OV] = s_r.acc_lim; // [R11]
    assign over_sel[ST_CELL_UV] = 1'b0;
    assign over_sel[ST_AUX_UV] = 1'b0;
    assign over_sel[ST_ACC_OV] = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ALERT; gi = gi + 1) begin : g_cmp
            cod_lim_cmp u_cmp (
                .value(meas.value),
                .limit(lim_sel[gi]),
                .over(over_sel[gi]),
                .hit(cmp_hit[gi])
            );
        end
    endgenerate

    assign set[ST_CELL_UV] = cell_open_scan && cmp_hit[ST_CELL_UV]; // [R01] [R03]
    assign set[ST_AUX_UV] = aux_open_scan && cmp_hit[ST_AUX_UV]; // [R04] [R06] [R08]
    assign set[ST_ACC_OV] = acc_scan && cmp_hit[ST_ACC_OV]; // [R11]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] clr;
        clr = 3'h0;
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        // One wait state: data is latched, then offered with pready
        if (access) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_data;
            s_nxt.pslverr = !hit_addr;
        end
        if (complete && pwrite && in_range) begin
            case (idx)
                IDX_CELL_LIM: begin
                    s_nxt.cell_lim = pwdata[LIM_MSB:LIM_LSB]; // [R09] [R13]
                end
                IDX_RATIO_LIM: begin
                    s_nxt.ratio_lim = pwdata[LIM_MSB:LIM_LSB]; // [R09] [R13]
                end
                IDX_ABS_LIM: begin
                    s_nxt.abs_lim = pwdata[LIM_MSB:LIM_LSB]; // [R09] [R13]
                end
                IDX_ACC_LIM: begin
                    s_nxt.acc_lim = pwdata[LIM_MSB:LIM_LSB]; // [R09] [R13]
                end
                IDX_CFG: begin
                    s_nxt.cfg.cell_open_sel = pwdata[CFG_CELL_OPEN];
                    s_nxt.cfg.aux_diag_sel = pwdata[CFG_AUX_DIAG_LSB +: 2];
                    s_nxt.cfg.scan_cfg = pwdata[CFG_SCAN_LSB +: 3];
                    s_nxt.cfg.acc_en = pwdata[CFG_ACC_EN];
                    s_nxt.cfg.aux_ref_sel = pwdata[CFG_AUX_REF_LSB +: NUM_AUX];
                end
                IDX_MASK: begin
                    s_nxt.mask = pwdata[NUM_ALERT-1:0];
                end
                default: begin
                    s_nxt.mask = s_r.mask;
                end
            endcase
        end
        // Clear only what the read returned, so a later event survives
        if (complete && !pwrite && in_range && (idx == IDX_STATUS)) begin
            clr = s_r.prdata[NUM_ALERT-1:0];
        end
        s_nxt.status = (s_r.status & ~clr) | set;
        s_nxt.irq = |(s_r.status & s_r.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.cell_lim <= LIM_RST_OPEN; // [R09]
            s_r.ratio_lim <= LIM_RST_OPEN; // [R09]
            s_r.abs_lim <= LIM_RST_OPEN; // [R09]
            s_r.acc_lim <= LIM_RST_ACC; // [R10]
            s_r.cfg <= '0;
            s_r.status <= 3'h0;
            s_r.mask <= 3'h0;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.prdata <= 32'h0000_0000;
            s_r.irq <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign cell_comp_uv_alert = s_r.status[ST_CELL_UV];
    assign aux_comp_uv_alert = s_r.status[ST_AUX_UV];
    assign comp_accuracy_ov_alert = s_r.status[ST_ACC_OV];
    assign irq = s_r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cell_uv_set: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
        (meas.valid && meas.src == SRC_CELL && meas.unipolar && s_r.cfg.cell_open_sel &&
         s_r.cell_lim != 12'h000 && meas.value < s_r.cell_lim) |=> cell_comp_uv_alert)
        else $error("cell open undervoltage did not raise alert");

    a_cell_uv_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R02] [R03]
        $rose(cell_comp_uv_alert) |-> $past(meas.valid && meas.src == SRC_CELL &&
        meas.unipolar && s_r.cfg.cell_open_sel && s_r.cell_lim != 12'h000 &&
        meas.value < s_r.cell_lim))
        else $error("cell alert set without qualifying open scan");

    a_aux_ratio_set: assert property (@(posedge pclk) disable iff (!presetn) // [R04] [R05]
        (aux_open_scan && !aux_ref && s_r.ratio_lim != 12'h000 &&
         meas.value < s_r.ratio_lim) |=> aux_comp_uv_alert)
        else $error("ratiometric aux open undervoltage missed");

    a_aux_abs_set: assert property (@(posedge pclk) disable iff (!presetn) // [R06] [R07]
        (aux_open_scan && aux_ref && s_r.abs_lim != 12'h000 &&
         meas.value < s_r.abs_lim) |=> aux_comp_uv_alert)
        else $error("absolute aux open undervoltage missed");

    a_aux_uv_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
        $rose(aux_comp_uv_alert) |-> $past(aux_open_scan &&
        (aux_ref ? (s_r.abs_lim != 12'h000 && meas.value < s_r.abs_lim)
                 : (s_r.ratio_lim != 12'h000 && meas.value < s_r.ratio_lim))))
        else $error("aux alert set by disabled or unselected limit");

    a_acc_ov_set: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (acc_scan && s_r.acc_lim != 12'hFFF && meas.value > s_r.acc_lim)
        |=> comp_accuracy_ov_alert)
        else $error("accuracy overvoltage did not raise alert");

    a_acc_ov_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        $rose(comp_accuracy_ov_alert) |-> $past(s_r.cfg.acc_en &&
        (s_r.cfg.scan_cfg == 3'h1 || s_r.cfg.scan_cfg == 3'h2) && meas.src == SRC_ACC))
        else $error("accuracy alert outside enabled scan configuration");

    a_lim_low_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (complete && !pwrite && in_range && is_lim) |-> prdata[3:0] == 4'h0)
        else $error("limit register low nibble not zero");

    a_lim_write: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        (complete && pwrite && in_range && idx == IDX_ACC_LIM)
        |=> s_r.acc_lim == $past(pwdata[15:4]))
        else $error("accuracy limit write not stored");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (|(s_r.status & s_r.mask)) |=> irq)
        else $error("interrupt not raised for unmasked alert");

    a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");

    // Set wins over clear so an alert landing on the read is not lost
    a_clear_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (complete && !pwrite && in_range && idx == IDX_STATUS && set != 3'h0)
        |=> (s_r.status & $past(set)) == $past(set))
        else $error("alert event lost to a status clear");

    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (complete && !pwrite && in_range && idx == IDX_STATUS && set == 3'h0)
        |=> (s_r.status & $past(prdata[NUM_ALERT-1:0])) == 3'h0)
        else $error("returned status bits not cleared");

    a_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(s_r.status & s_r.mask)) |=> !irq)
        else $error("interrupt high with no unmasked alert");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && !hit_addr) |-> pslverr)
        else $error("unmapped access not refused");

    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && hit_addr) |-> !pslverr)
        else $error("mapped access refused");

    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("apb ready held longer than one cycle");

    a_lim_reset: assert property (@(posedge pclk) // [R09] [R10]
        $rose(presetn) |-> (s_r.cell_lim == LIM_RST_OPEN && s_r.ratio_lim == LIM_RST_OPEN &&
        s_r.abs_lim == LIM_RST_OPEN && s_r.acc_lim == LIM_RST_ACC))
        else $error("limit reset values wrong");

    a_cell_lim_write: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        (complete && pwrite && in_range && idx == IDX_CELL_LIM)
        |=> s_r.cell_lim == $past(pwdata[LIM_MSB:LIM_LSB]))
        else $error("cell open limit write not stored");

    a_ratio_lim_write: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        (complete && pwrite && in_range && idx == IDX_RATIO_LIM)
        |=> s_r.ratio_lim == $past(pwdata[LIM_MSB:LIM_LSB]))
        else $error("ratiometric limit write not stored");

    a_abs_lim_write: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        (complete && pwrite && in_range && idx == IDX_ABS_LIM)
        |=> s_r.abs_lim == $past(pwdata[LIM_MSB:LIM_LSB]))
        else $error("absolute limit write not stored");

endmodule
`default_nettype wire

// File: dv/test_cod_thresh_bank.sv
// Self-checking APB testbench for the threshold bank
`timescale 1ns/1ns
`default_nettype none
module test_cod_thresh_bank
    import cod_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cod_meas_t meas = '0;
    logic cell_a;
    logic aux_a;
    logic acc_a;
    logic irq;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic er;
    logic [2:0] mask_m = 3'h0;
    logic [7:0] lims [4] = '{IDX_CELL_LIM, IDX_RATIO_LIM, IDX_ABS_LIM, IDX_ACC_LIM};

    always #10 pclk = ~pclk;

    cod_thresh_bank u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas(meas), .cell_comp_uv_alert(cell_a), .aux_comp_uv_alert(aux_a),
        .comp_accuracy_ov_alert(acc_a), .irq(irq)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Master never assumes the one wait state; it polls under a bound
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20 && pready !== 1'b1) begin
            $display("[FAIL] t=%0t pready=%h exp=%h", $time, pready, 1'b1);
            fail_count++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, rd, er);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0000_0000);
    endtask

    // One valid measurement pulse, then alerts, irq, status read and clear
    task automatic ev(input logic [1:0] s, input logic [2:0] c, input logic u,
                      input logic [11:0] v, input logic [2:0] exp);
        @(posedge pclk);
        meas <= {1'b1, s, c, u, v};
        @(posedge pclk);
        meas <= {1'b0, s, c, u, v};
        repeat (2) @(posedge pclk);
        #1;
        chk({29'h0, acc_a, aux_a, cell_a}, {29'h0, exp});
        chk({31'h0, irq}, {31'h0, |(exp & mask_m)});
        rdc(IDX_STATUS, {29'h0, exp});
        @(posedge pclk);
        #1;
        chk({28'h0, irq, acc_a, aux_a, cell_a}, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(IDX_CELL_LIM, 32'h0000_0000);
        rdc(IDX_RATIO_LIM, 32'h0000_0000);
        rdc(IDX_ABS_LIM, 32'h0000_0000);
        rdc(IDX_ACC_LIM, 32'h0000_FFF0);
        rdc(IDX_STATUS, 32'h0000_0000);
        rdc(IDX_MASK, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(lims[i], 32'hFFFF_FFFF);
            rdc(lims[i], 32'h0000_FFF0);
            wr(lims[i], 32'h1234_5678);
            rdc(lims[i], 32'h0000_5670);
        end
        // Unmapped index must refuse with an error and zero data
        apb(1'b0, 8'h30, 32'h0000_0000, rd, er);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        wr(IDX_STATUS, 32'h0000_0007);
        rdc(IDX_STATUS, 32'h0000_0000);
        wr(IDX_CELL_LIM, 32'h0000_1000);
        wr(IDX_RATIO_LIM, 32'h0000_2000);
        wr(IDX_ABS_LIM, 32'h0000_3000);
        wr(IDX_ACC_LIM, 32'h0000_3FF0);
        wr(IDX_MASK, 32'h0000_0007);
        mask_m = 3'h7;
        rdc(IDX_MASK, 32'h0000_0007);
        // Cell open on, aux open mode, scan 001, accuracy on, aux 1 absolute
        wr(IDX_CFG, 32'h0000_024B);
        rdc(IDX_CFG, 32'h0000_024B);
        ev(SRC_CELL, 3'h0, 1'b1, 12'h0FF, 3'h1);
        ev(SRC_CELL, 3'h0, 1'b1, 12'h100, 3'h0);
        ev(SRC_CELL, 3'h0, 1'b0, 12'h000, 3'h0);
        ev(SRC_AUX, 3'h0, 1'b0, 12'h1FF, 3'h2);
        ev(SRC_AUX, 3'h0, 1'b0, 12'h250, 3'h0);
        ev(SRC_AUX, 3'h1, 1'b0, 12'h250, 3'h2);
        ev(SRC_AUX, 3'h1, 1'b0, 12'h300, 3'h0);
        ev(SRC_AUX, 3'h6, 1'b0, 12'h250, 3'h0);
        ev(SRC_ACC, 3'h0, 1'b0, 12'h400, 3'h4);
        ev(SRC_ACC, 3'h0, 1'b0, 12'h3FF, 3'h4 & 3'h0);
        // Event on the completion edge of a status read survives it
        fork
            apb(1'b0, IDX_STATUS, 32'h0000_0000, rd, er);
            begin
                repeat (3) @(posedge pclk);
                meas <= {1'b1, SRC_CELL, 3'h0, 1'b1, 12'h0FF};
                @(posedge pclk);
                meas <= '0;
            end
        join
        chk(rd, 32'h0000_0000);
        #1;
        chk({31'h0, cell_a}, 32'h0000_0001);
        rdc(IDX_STATUS, 32'h0000_0001);
        wr(IDX_MASK, 32'h0000_0002);
        mask_m = 3'h2;
        ev(SRC_CELL, 3'h0, 1'b1, 12'h000, 3'h1);
        ev(SRC_AUX, 3'h0, 1'b0, 12'h000, 3'h2);
        wr(IDX_CFG, 32'h0000_024A);
        ev(SRC_CELL, 3'h0, 1'b1, 12'h0FF, 3'h0);
        wr(IDX_CFG, 32'h0000_025A);
        ev(SRC_ACC, 3'h0, 1'b0, 12'h400, 3'h0);
        wr(IDX_CFG, 32'h0000_0252);
        ev(SRC_ACC, 3'h0, 1'b0, 12'h400, 3'h4);
        wr(IDX_CFG, 32'h0000_0212);
        ev(SRC_ACC, 3'h0, 1'b0, 12'h400, 3'h0);
        wr(IDX_CFG, 32'h0000_0255);
        ev(SRC_AUX, 3'h0, 1'b0, 12'h000, 3'h0);
        ev(SRC_CELL, 3'h0, 1'b1, 12'h0FF, 3'h1);
        // All limits at their disable values
        wr(IDX_CFG, 32'h0000_0253);
        wr(IDX_CELL_LIM, 32'h0000_0000);
        wr(IDX_RATIO_LIM, 32'h0000_0000);
        wr(IDX_ABS_LIM, 32'h0000_0000);
        wr(IDX_ACC_LIM, 32'h0000_FFF0);
        ev(SRC_CELL, 3'h0, 1'b1, 12'h000, 3'h0);
        ev(SRC_AUX, 3'h0, 1'b0, 12'h000, 3'h0);
        ev(SRC_AUX, 3'h1, 1'b0, 12'h000, 3'h0);
        ev(SRC_ACC, 3'h0, 1'b0, 12'hFFF, 3'h0);
        wr(IDX_ACC_LIM, 32'h0000_FFE0);
        ev(SRC_ACC, 3'h0, 1'b0, 12'hFFF, 3'h4);
        results();
    end

endmodule
`default_nettype wire
